// file: hw/alfr_core.sv
`timescale 1ns/100ps
`include "alfr_defs.svh"

// ---------------------------------------------------------------------------
// Opcode match
// ---------------------------------------------------------------------------
// One comparator per load instruction, so that a neighbouring transfer can be
// added as one more instance rather than as a new decode branch.
module alfr_op_match #(
  parameter int unsigned            WORD_W = 10,
  parameter logic [WORD_W-1:0]      OPCODE = {WORD_W{1'b0}}
) (
  input  wire logic                 valid,
  input  wire logic [WORD_W-1:0]    word,
  output logic                      match
);

  assign match = valid && (word == OPCODE);

endmodule

module alfr_core (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire alfr_pkg::alfr_instr_t instr,
  input  wire alfr_pkg::alfr_src_t   src,
  input  wire logic                 acc_wr_en,
  input  wire logic [3:0]           acc_wr_data,
  output logic                      hit,
  output logic                      skip_req,
  output logic                      carry_wr_en,
  output logic [3:0]                acc
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  alfr_pkg::alfr_sel_t sel;
  logic [3:0]          next_acc;
  logic                match_stack;
  logic                match_ic1;
  logic                match_ic2;
  logic                match_tc1;

  alfr_op_match #(
    .WORD_W (10),
    .OPCODE (`ALFR_OP_LOAD_STACK)
  ) u_match_stack (
    .valid  (instr.valid),
    .word   (instr.word),
    .match  (match_stack)
  );

  alfr_op_match #(
    .WORD_W (10),
    .OPCODE (`ALFR_OP_LOAD_IC1)
  ) u_match_ic1 (
    .valid  (instr.valid),
    .word   (instr.word),
    .match  (match_ic1)
  );

  alfr_op_match #(
    .WORD_W (10),
    .OPCODE (`ALFR_OP_LOAD_IC2)
  ) u_match_ic2 (
    .valid  (instr.valid),
    .word   (instr.word),
    .match  (match_ic2)
  );

  alfr_op_match #(
    .WORD_W (10),
    .OPCODE (`ALFR_OP_LOAD_TC1)
  ) u_match_tc1 (
    .valid  (instr.valid),
    .word   (instr.word),
    .match  (match_tc1)
  );

  // The opcodes are distinct, so at most one match is high; the order below
  // only fixes a value for the synthesiser.
  always_comb begin
    sel = alfr_pkg::ALFR_NONE;
    if (match_stack) begin
      sel = alfr_pkg::ALFR_SEL_STACK;
    end else if (match_ic1) begin
      sel = alfr_pkg::ALFR_IC1;
    end else if (match_ic2) begin
      sel = alfr_pkg::ALFR_IC2;
    end else if (match_tc1) begin
      sel = alfr_pkg::ALFR_TC1;
    end
  end

  // Sources are only read, never written back, and neither carry nor skip is
  // ever requested by these loads.
  assign hit         = (sel != alfr_pkg::ALFR_NONE);
  assign skip_req    = 1'b0;
  assign carry_wr_en = 1'b0;

  // ---------------------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------------------
  // A decoded load wins over an acc_wr_en write in the same cycle, but sys_rst
  // wins over the load; only one instruction executes per cycle.
  always_comb begin
    next_acc = acc;
    case (sel)
      alfr_pkg::ALFR_SEL_STACK:
        next_acc = {1'b0, src.stack_pointer[`ALFR_STACK_MSB:0]};
      alfr_pkg::ALFR_IC1: next_acc = src.int_ctrl_one;
      alfr_pkg::ALFR_IC2: next_acc = src.int_ctrl_two;
      alfr_pkg::ALFR_TC1: next_acc = src.timer_ctrl_one;
      default: begin
        if (acc_wr_en) begin
          next_acc = acc_wr_data;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc <= `ALFR_ACC_RESET;
    end else begin
      acc <= next_acc;
    end
  end

endmodule

// file: hw/alfr_defs.svh
`ifndef ALFR_DEFS_SVH
`define ALFR_DEFS_SVH

// ---------------------------------------------------------------------------
// Opcodes, accumulator reset value and stack pointer MSB
// ---------------------------------------------------------------------------
`define ALFR_OP_LOAD_STACK 10'h050
`define ALFR_OP_LOAD_IC1 10'h054
`define ALFR_OP_LOAD_IC2 10'h055
`define ALFR_OP_LOAD_TC1 10'h24B
`define ALFR_ACC_RESET   4'h0
`define ALFR_STACK_MSB   2

`endif

// file: hw/alfr_pkg.sv
package alfr_pkg;

  typedef enum logic [2:0] {
    ALFR_NONE,
    ALFR_SEL_STACK,
    ALFR_IC1,
    ALFR_IC2,
    ALFR_TC1
  } alfr_sel_t;

  // Instruction word presented for execution in this cycle.
  typedef struct packed {
    logic       valid;
    logic [9:0] word;
  } alfr_instr_t;

  // Sources the core offers for reading.
  typedef struct packed {
    logic [2:0] stack_pointer;
    logic [3:0] int_ctrl_one;
    logic [3:0] int_ctrl_two;
    logic [3:0] timer_ctrl_one;
  } alfr_src_t;

endpackage

// file: sim/alfr_core_asserts.sv
`timescale 1ns/100ps
module alfr_core_chk (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire alfr_pkg::alfr_instr_t instr,
  input wire alfr_pkg::alfr_src_t   src,
  input wire logic                  skip_req,
  input wire logic                  carry_wr_en,
  input wire logic [3:0]            acc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_stack; instr == 11'h450 |=>
    acc == {1'b0, $past(src.stack_pointer)}; endproperty
  a_stack: assert property (p_stack) else $error("stack load");
  property p_ic1; instr == 11'h454 |=>
    acc == $past(src.int_ctrl_one); endproperty
  a_ic1: assert property (p_ic1) else $error("ic1 load");
  property p_ic2; instr == 11'h455 |=>
    acc == $past(src.int_ctrl_two); endproperty
  a_ic2: assert property (p_ic2) else $error("ic2 load");
  property p_tc1; instr == 11'h64B |=>
    acc == $past(src.timer_ctrl_one); endproperty
  a_tc1: assert property (p_tc1) else $error("tc1 load");
  property p_side; !skip_req && !carry_wr_en; endproperty
  a_side: assert property (p_side) else $error("side");
endmodule
bind alfr_core alfr_core_chk u_chk (.clk_sys, .sys_rst, .instr, .src,
  .skip_req, .carry_wr_en, .acc);

// file: sim/tb_accumulator_load_from_regs.sv
`timescale 1ns/100ps
module tb_accumulator_load_from_regs;
  logic                  clk_sys = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  acc_wr_en = 1'b0;
  logic                  hit;
  logic                  skip_req;
  logic                  carry_wr_en;
  logic [3:0]            acc_wr_data = 4'h0;
  logic [3:0]            acc;
  logic [3:0]            ea = 4'h0;
  alfr_pkg::alfr_instr_t instr = '0;
  alfr_pkg::alfr_src_t   src = '0;
  int                    seed = 32'hF5C6;
  int                    mismatches = 0;
  int                    total_checks = 0;
  logic [9:0]            ops [6] = '{10'h050, 10'h054, 10'h055, 10'h24B,
                                    10'h056, 10'h24C};
  alfr_core dut (.clk_sys, .sys_rst, .instr, .src, .acc_wr_en,
    .acc_wr_data, .hit, .skip_req, .carry_wr_en, .acc);
  function automatic logic is_load(logic [9:0] w);
    return w == 10'h050 || w == 10'h054 || w == 10'h055 || w == 10'h24B;
  endfunction
  function automatic logic [3:0] nxt(logic [3:0] a);
    // A load wins over a write from other core logic in the same cycle.
    logic [3:0] w = acc_wr_en ? acc_wr_data : a;
    if (!instr.valid) return w;
    case (instr.word)
      10'h050: return {1'b0, src.stack_pointer};
      10'h054: return src.int_ctrl_one;
      10'h055: return src.int_ctrl_two;
      10'h24B: return src.timer_ctrl_one;
      default: return w;
    endcase
  endfunction
  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #10 clk_sys = ~clk_sys;
  initial begin
    #20000;
    mismatches++;
    results;
  end
  task automatic step(input logic rst, input logic v, input logic [9:0] w,
                      input logic [14:0] s, input logic we,
                      input logic [3:0] wd);
    logic [6:0] e;
    logic [6:0] g;
    @(posedge clk_sys);
    sys_rst     <= rst;
    instr       <= '{valid: v, word: w};
    src         <= s;
    acc_wr_en   <= we;
    acc_wr_data <= wd;
    @(negedge clk_sys);
    e = {ea, instr.valid && is_load(instr.word), 2'b00};
    g = {acc, hit, skip_req, carry_wr_en};
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t %h %h", $time, g, e);
    end
    ea = sys_rst ? 4'h0 : nxt(ea);
  endtask
  initial begin
    logic       rr;
    logic       rv;
    logic       re;
    logic [9:0] rw;
    logic [14:0] rs;
    logic [3:0] rd;
    repeat (7) @(posedge clk_sys);
    // Corners: a load beats a same-cycle write, the stack load clears bit 3
    // with every source bit set, and reset beats a load.
    step(1'b0, 1'b1, 10'h050, 15'h7FFF, 1'b1, 4'hF);
    step(1'b0, 1'b1, 10'h054, 15'h0A00, 1'b1, 4'h5);
    step(1'b0, 1'b1, 10'h055, 15'h00C0, 1'b1, 4'h3);
    step(1'b0, 1'b1, 10'h24B, 15'h0009, 1'b0, 4'h0);
    step(1'b0, 1'b1, 10'h24C, 15'h7FFF, 1'b1, 4'h6);
    step(1'b0, 1'b0, 10'h050, 15'h7FFF, 1'b0, 4'h0);
    step(1'b1, 1'b1, 10'h054, 15'h0F00, 1'b0, 4'h0);
    step(1'b0, 1'b1, 10'h050, 15'h5000, 1'b0, 4'h0);
    repeat (600) begin
      rr = ($random(seed) & 63) == 0;
      rv = 1'($random(seed));
      rw = ops[{$random(seed)} % 6];
      rs = 15'($random(seed));
      re = 1'($random(seed));
      rd = 4'($random(seed));
      step(rr, rv, rw, rs, re, rd);
    end
    results;
  end
endmodule
